// ===== verif/vss_top_tb.sv
// self-checking bench for the vertical sync separator
`timescale 1ns/1ps
`default_nettype none

module vss_top_tb;
	localparam logic [9:0] TIP_MV = 10'h064;
	logic       clk      = 1'b0;
	logic       rst_n    = 1'b0;
	logic       sync_req = 1'b0;
	logic [9:0] probe    = 10'h000;
	logic [7:0] setting  = 8'h01;
	logic [9:0] video;
	logic       cs_n, vs_n, odd;
	logic       exp_now = 1'b0, exp_q = 1'b0, cs_on = 1'b0;
	int         n_mismatch = 0, n_tests = 0;
	int         cyc = 0, run = 0, npulse = 0, t_fall = 0, width = 0;

	// 40 MHz system clock
	always #12.5 clk = ~clk;

	vss_video_src i_vss_video_src (.clk_i(clk), .sync_i(sync_req), .probe_i(probe),
		.video_o(video));
	vss_top i_vss_top (.CLK_SYS_I(clk), .RST_N_I(rst_n), .VIDEO_I(video),
		.TIMING_SETTING_I(setting), .CSYNC_N_O(cs_n), .VSYNC_N_O(vs_n), .FIELD_ODD_O(odd));

	//--------------------------------------------------------------------------
	// checking and bookkeeping
	//--------------------------------------------------------------------------
	task automatic chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : chk

	task automatic close_out;
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out

	// slicer expectation lags the sample by one edge
	always @(posedge clk)
		exp_q <= exp_now;

	// slicer watch and vertical pulse timing, sampled mid-cycle
	always @(negedge clk)
	begin
		cyc <= cyc + 1;
		if (cs_on)
			chk(cs_n === ~exp_q, "composite sync mismatch");
		if (vs_n === 1'b0)
		begin
			run <= run + 1;
			if (run == 0)
			begin
				npulse <= npulse + 1;
				t_fall <= cyc;
			end
		end
		else if (run != 0)
		begin
			width <= run;
			run   <= 0;
		end
	end

	//--------------------------------------------------------------------------
	// stimulus and scenarios
	//--------------------------------------------------------------------------
	task automatic drv(input logic s, input int n, input logic [9:0] p = 10'h000);
		sync_req = s;
		probe    = p;
		exp_now  = s | (p != 10'h000 && p <= TIP_MV + 10'h046);
		repeat (n) @(negedge clk);
	endtask : drv

	task automatic line(input int k);
		repeat (k)
		begin
			drv(1'b1, 5);
			drv(1'b0, 59);
		end
	endtask : line

	// line syncs never start a pulse; slicer edge just above and at threshold
	task automatic t_slice;
		int n0;
		n0 = npulse;
		line(4);
		drv(1'b1, 5);
		drv(1'b0, 1, TIP_MV + 10'h047);
		drv(1'b0, 1, TIP_MV + 10'h046);
		drv(1'b0, 60);
		chk(npulse === n0, "pulse from line syncs");
	endtask : t_slice

	// broad sync with serrations; pulse count, start offset and width
	task automatic t_vert(input logic [7:0] s, input int broad, input int gap,
		input int nser, input int np, input int off, input int w);
		int n0, t0;
		setting = s;
		line(3);
		n0 = npulse;
		t0 = cyc;
		repeat (nser)
		begin
			drv(1'b1, broad);
			drv(1'b0, gap);
		end
		line(w / 64 + 3);
		chk(npulse === n0 + np, "vertical pulse count");
		if (off >= 0)
			chk(t_fall - t0 === off, "vertical pulse start");
		if (np > 0)
			chk(width === w, "vertical pulse width");
	endtask : t_vert

	// long quiet gap, then k line syncs before the broad sync
	task automatic t_field(input int k, input logic exp_odd);
		drv(1'b0, 1700);
		line(k);
		drv(1'b1, 21);
		drv(1'b0, 3);
		line(6);
		chk(odd === exp_odd, "field parity");
	endtask : t_field

	// reset in the middle of a running pulse
	task automatic t_rst;
		drv(1'b1, 21);
		drv(1'b0, 3);
		line(1);
		cs_on = 1'b0;
		rst_n = 1'b0;
		drv(1'b0, 2);
		chk(vs_n === 1'b1 && odd === 1'b0 && cs_n === 1'b1, "mid-run reset");
		rst_n = 1'b1;
		line(2);
		cs_on = 1'b1;
	endtask : t_rst

	// main sequence
	initial
	begin
		repeat (10) @(negedge clk);
		chk(cs_n === 1'b1 && vs_n === 1'b1 && odd === 1'b0, "reset state");
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		line(2);
		cs_on = 1'b1;
		t_slice;
		t_vert(8'h01, 21, 3, 1, 1, 22, 256);
		t_vert(8'h00, 21, 3, 1, 1, 22, 256);
		t_vert(8'h02, 40, 4, 1, 1, 41, 512);
		t_vert(8'h08, 100, 3, 1, 0, -1, 256);
		t_vert(8'h01, 21, 3, 15, 2, -1, 256);
		t_vert(8'h01, 29, 3, 15, 1, 30, 512);
		t_vert(8'h01, 100, 3, 1, 1, 49, 256);
		t_vert(8'h01, 400, 3, 1, 2, 401, 256);
		t_field(3, 1'b1);
		t_field(4, 1'b0);
		t_rst;
		line(2);
		close_out;
	end

	// watchdog, well beyond the expected run length
	initial
	begin
		#1000000;
		n_mismatch++;
		close_out;
	end
endmodule : vss_top_tb

`default_nettype wire

// ===== verif/vss_video_src.sv
// video source model: negative going sync with moving picture above black
`timescale 1ns/1ps
`default_nettype none

module vss_video_src
(
	// clock
	input  wire logic       clk_i,
	// requested sync and forced test level
	input  wire logic       sync_i,
	input  wire logic [9:0] probe_i,
	// video samples in millivolts
	output logic      [9:0] video_o
);
	logic [7:0] ramp = 8'h00;

	// picture content moves every cycle so it never parks at one level
	always @(negedge clk_i)
		ramp <= ramp + 8'h07;

	// sync tip at 100 mV, picture from 400 mV upward, probe overrides both
	always_comb
		if (probe_i != 10'h000)
			video_o = probe_i;
		else if (sync_i)
			video_o = 10'h064;
		else
			video_o = 10'h190 + {2'h0, ramp};
endmodule : vss_video_src

`default_nettype wire

// ===== verilog/vss_pkg.sv
// constants and carrier types for the vertical sync separator
//------------------------------------------------------------------------------
// Functional notes
// - composite sync output keeps only below-black portion
// - slicer fires within 70 mV above sync tip
// - integrator charges only while inverted sync asserted
// - integrator passes trigger level by first serration
// - capture trigger comparator at each serration edge
// - capture or default comparator sets vertical flip-flop
// - vertical set enables oscillator, clocks field parity
// - divide-by-eight of oscillator resets vertical flip-flop
// - vertical output is inverted vertical flip-flop state
// - timing setting sets oscillator period and charge
// - too slow charge gives no vertical pulse
// - early pulse end retriggers on later serration
// - default level reached sets vertical flip-flop
// - trailing sync edge after default pulse retriggers
// - field parity low in even, high in odd
//------------------------------------------------------------------------------
`default_nettype none

package vss_pkg;

	//--------------------------------------------------------------------------
	// clock and timing
	//--------------------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ       = 40_000_000;
	localparam int unsigned FIELD_GAP_US      = 40; // gap longer than a half line
	localparam int unsigned FIELD_GAP_CYC_INT = (FIELD_GAP_US * CLK_FREQ_HZ + 999_999) / 1_000_000;
	localparam logic [10:0] FIELD_GAP_CYC     = 11'(FIELD_GAP_CYC_INT);
	localparam logic [10:0] GAP_MAX           = 11'h7FF;

	//--------------------------------------------------------------------------
	// slicer, sample units are millivolts
	//--------------------------------------------------------------------------
	localparam logic [10:0] THRESH_MV    = 11'h046; // 70 mV above the sync tip
	localparam logic [9:0]  TIP_RESET    = 10'h3FF;
	localparam logic [9:0]  TIP_MAX      = 10'h3FF;
	localparam logic [5:0]  TIP_LEAK_CYC = 6'h3F;   // slow tip discharge

	//--------------------------------------------------------------------------
	// integrator, comparator levels and oscillator scaling
	//--------------------------------------------------------------------------
	localparam logic [15:0] INTEG_RESET  = 16'h0000;
	localparam logic [15:0] INTEG_MAX    = 16'hFFFF;
	localparam logic [7:0]  SETTING_MIN  = 8'h01;
	localparam logic [15:0] TRIG_MULT    = 16'h0010;
	localparam logic [15:0] DEFAULT_MULT = 16'h0030;
	localparam logic [15:0] OSC_MULT     = 16'h0020;
	localparam logic [2:0]  DIV_LAST     = 3'h7;     // divide by eight

	//--------------------------------------------------------------------------
	// carriers and state
	//--------------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] trigger;
		logic [15:0] dflt;
		logic [15:0] osc_period;
	} vss_level_type;

	typedef struct packed {
		logic [15:0] cnt;
		logic [2:0]  div;
	} vss_timer_state_type;

	typedef struct packed {
		logic [9:0]  tip;
		logic [5:0]  leak;
		logic        sync;
		logic [15:0] integ;
		logic        vert;
		logic        toggle;
		logic [10:0] gap;
		logic        odd;
	} vss_top_state_type;

endpackage : vss_pkg

`default_nettype wire

// ===== verilog/vss_pulse_timer.sv
// gated oscillator with divide-by-eight that ends the vertical pulse
`timescale 1ns/1ps
`default_nettype none

module vss_pulse_timer
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// control
	input  wire logic        run_i,
	input  wire logic [15:0] period_i,
	// events
	output logic             tick_o,
	output logic             done_o
);

	vss_pkg::vss_timer_state_type r;
	vss_pkg::vss_timer_state_type next_r;

	//--------------------------------------------------------------------------
	// oscillator and divider
	//--------------------------------------------------------------------------

	// oscillator only runs while enabled, restarts from zero on each enable
	always_comb
	begin
		next_r = r;
		tick_o = 1'b0;
		done_o = 1'b0;
		if (!run_i)
		begin
			next_r.cnt = 16'h0000;
			next_r.div = 3'h0;
		end
		else if (({1'b0, r.cnt} + 17'h00001) >= {1'b0, period_i})
		begin
			tick_o     = 1'b1;
			next_r.cnt = 16'h0000;
			next_r.div = r.div + 3'h1;
			done_o     = (r.div == vss_pkg::DIV_LAST);
		end
		else
		begin
			next_r.cnt = r.cnt + 16'h0001;
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end

	//--------------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------------
	a_timer_idle_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!run_i |=> (r.cnt == 16'h0000) && (r.div == 3'h0))
		else $error("timer state not cleared while idle");

endmodule : vss_pulse_timer

`default_nettype wire

// ===== verilog/vss_top.sv
// vertical sync separator: slicer, integrator, vertical pulse and field parity
`timescale 1ns/1ps
`default_nettype none

module vss_top
(
	// clock and reset
	input  wire logic       CLK_SYS_I,
	input  wire logic       RST_N_I,
	// video samples in millivolts, from a converter on the same clock
	input  wire logic [9:0] VIDEO_I,
	// timing setting, sets charge rate and oscillator period
	input  wire logic [7:0] TIMING_SETTING_I,
	// sync outputs
	output logic            CSYNC_N_O,
	output logic            VSYNC_N_O,
	output logic            FIELD_ODD_O
);

	//--------------------------------------------------------------------------
	// declarations
	//--------------------------------------------------------------------------
	vss_pkg::vss_top_state_type r;
	vss_pkg::vss_top_state_type next_r;
	vss_pkg::vss_level_type     lv;

	logic [7:0]  setting;      // clamped timing setting
	logic        sync_start;   // leading edge of a sync pulse
	logic        sync_end;     // trailing edge, serration start
	logic        trig_hit;     // trigger level comparator
	logic        capture_evt;  // capture flip-flop takes a high
	logic        default_evt;  // default level comparator crossing
	logic        set_evt;      // set input of the vertical flip-flop
	logic        timer_tick;
	logic        timer_done;
	logic [19:0] pulse_len;    // cycles since vertical set, checks only

	//--------------------------------------------------------------------------
	// comparator levels from the timing setting
	//--------------------------------------------------------------------------

	// a zero setting would collapse every level, so it is held at one
	always_comb
	begin
		setting = TIMING_SETTING_I;
		if (TIMING_SETTING_I < vss_pkg::SETTING_MIN)
		begin
			setting = vss_pkg::SETTING_MIN;
		end
		// larger setting means slower charge: both levels move up
		lv.trigger    = {8'h00, setting} * vss_pkg::TRIG_MULT;
		lv.dflt       = {8'h00, setting} * vss_pkg::DEFAULT_MULT;
		lv.osc_period = {8'h00, setting} * vss_pkg::OSC_MULT;
	end

	//--------------------------------------------------------------------------
	// next state
	//--------------------------------------------------------------------------

	// slicer, integrator, vertical flip-flop and parity in one pass
	always_comb
	begin
		next_r = r;

		// sync tip follows the input down at once and drifts up slowly
		if (VIDEO_I < r.tip)
		begin
			next_r.tip  = VIDEO_I;
			next_r.leak = 6'h00;
		end
		else if (r.leak == vss_pkg::TIP_LEAK_CYC)
		begin
			next_r.leak = 6'h00;
			if (r.tip != vss_pkg::TIP_MAX)
			begin
				next_r.tip = r.tip + 10'h001;
			end
		end
		else
		begin
			next_r.leak = r.leak + 6'h01;
		end

		// fixed offset above the tip, so amplitude does not matter
		next_r.sync = ({1'b0, VIDEO_I} <= ({1'b0, r.tip} + vss_pkg::THRESH_MV));

		// integrator runs only during inverted sync
		if (r.sync)
		begin
			if (r.integ != vss_pkg::INTEG_MAX)
			begin
				next_r.integ = r.integ + 16'h0001;
			end
		end
		else
		begin
			next_r.integ = vss_pkg::INTEG_RESET;
		end

		// edges of the sliced sync
		sync_start = !r.sync && next_r.sync;
		sync_end   = r.sync && !next_r.sync;

		// capture at the serration edge; a short broad pulse never gets here
		trig_hit    = (r.integ >= lv.trigger);
		capture_evt = sync_end && trig_hit;
		default_evt = r.sync && (next_r.integ >= lv.dflt)
			&& (r.integ < lv.dflt);
		set_evt     = capture_evt || default_evt;

		// set wins over the divider reset, so a late serration retriggers
		if (set_evt)
		begin
			next_r.vert = 1'b1;
		end
		else if (timer_done)
		begin
			next_r.vert = 1'b0;
		end

		// long gap between sync pulses clears the toggle, short ones flip it
		if (r.sync)
		begin
			next_r.gap = 11'h000;
		end
		else if (r.gap != vss_pkg::GAP_MAX)
		begin
			next_r.gap = r.gap + 11'h001;
		end
		if (sync_start)
		begin
			if (r.gap >= vss_pkg::FIELD_GAP_CYC)
			begin
				next_r.toggle = 1'b0;
			end
			else
			begin
				next_r.toggle = !r.toggle;
			end
		end

		// the rising vertical flip-flop clocks the parity flip-flop
		if (set_evt && !r.vert)
		begin
			next_r.odd = r.toggle;
		end
	end

	//--------------------------------------------------------------------------
	// state register
	//--------------------------------------------------------------------------

	// everything clears except the tip, which loads TIP_RESET, so the vertical output idles high
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			r       <= '0;
			r.tip   <= vss_pkg::TIP_RESET;
			r.integ <= vss_pkg::INTEG_RESET;
		end
		else
		begin
			r <= next_r;
		end
	end

	//--------------------------------------------------------------------------
	// pulse oscillator and divide-by-eight
	//--------------------------------------------------------------------------

	// enabled only while the vertical flip-flop is set
	vss_pulse_timer u_timer
	(
		.clk_i    (CLK_SYS_I),
		.rst_n_i  (RST_N_I),
		.run_i    (r.vert),
		.period_i (lv.osc_period),
		.tick_o   (timer_tick),
		.done_o   (timer_done)
	);

	//--------------------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------------------

	// active low sync outputs straight from the state flops
	assign CSYNC_N_O   = !r.sync;
	assign VSYNC_N_O   = !r.vert;
	assign FIELD_ODD_O = r.odd;

	//--------------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------------

	// length of the current vertical pulse, for the width check
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			pulse_len <= 20'h00000;
		end
		else if (!r.vert || timer_done)
		begin
			pulse_len <= 20'h00000;
		end
		else
		begin
			pulse_len <= pulse_len + 20'h00001;
		end
	end

	default clocking cb @(posedge CLK_SYS_I);
	endclocking

	default disable iff (!RST_N_I);

	a_csync_slicer_low: assert property (
		({1'b0, VIDEO_I} <= ({1'b0, r.tip} + vss_pkg::THRESH_MV)) |=> !CSYNC_N_O)
		else $error("composite sync missing below slice level");

	a_csync_picture_off: assert property (
		({1'b0, VIDEO_I} > ({1'b0, r.tip} + vss_pkg::THRESH_MV)) |=> CSYNC_N_O)
		else $error("picture content leaked into composite sync");

	a_integ_clears_off: assert property (
		!r.sync |=> (r.integ == vss_pkg::INTEG_RESET))
		else $error("integrator did not clear outside sync");

	a_integ_counts_up: assert property (
		(r.sync && (r.integ != vss_pkg::INTEG_MAX))
		|=> (r.integ == ($past(r.integ) + 16'h0001)))
		else $error("integrator did not advance during sync");

	a_capture_sets_vert: assert property (
		(sync_end && (r.integ >= lv.trigger)) |=> (r.vert && !VSYNC_N_O))
		else $error("serration capture did not start vertical pulse");

	a_default_sets_vert: assert property (
		(r.sync && (r.integ < lv.dflt) && ((r.integ + 16'h0001) >= lv.dflt))
		|=> !VSYNC_N_O)
		else $error("default level did not start vertical pulse");

	a_no_spurious_vert: assert property (
		(!r.vert && !capture_evt && !default_evt) |=> VSYNC_N_O)
		else $error("vertical pulse without a trigger");

	a_pulse_eight_osc: assert property (
		timer_done |-> ((pulse_len + 20'h00001) == {1'b0, lv.osc_period, 3'h0}))
		else $error("vertical pulse not eight oscillator periods");

	a_vert_ends_done: assert property (
		(r.vert && timer_done && !set_evt) |=> (VSYNC_N_O && $stable(r.odd)))
		else $error("vertical pulse did not end on divider");

	a_parity_sampled: assert property (
		(set_evt && !r.vert) |=> (FIELD_ODD_O == $past(r.toggle)))
		else $error("field parity not taken at vertical start");

	a_parity_holds: assert property (
		!(set_evt && !r.vert) |=> $stable(FIELD_ODD_O))
		else $error("field parity changed mid field");

	//--------------------------------------------------------------------------
	// vertical flip-flop, divider and field toggle
	//--------------------------------------------------------------------------

	// the divider only ends a pulse on an oscillator cycle
	a_done_on_tick: assert property (
		timer_done |-> timer_tick)
		else $error("divider finished without an oscillator cycle");

	// the oscillator is gated off while no vertical pulse runs
	a_osc_gated_off: assert property (
		!r.vert |-> !timer_tick)
		else $error("pulse oscillator ran outside a vertical pulse");

	// the clamped setting keeps the oscillator slower than the clock
	a_osc_tick_spaced: assert property (
		timer_tick |=> !timer_tick)
		else $error("pulse oscillator period too short");

	// between divider ends a set vertical flip-flop stays set
	a_vert_holds_set: assert property (
		(r.vert && !timer_done) |=> (r.vert && !VSYNC_N_O))
		else $error("vertical pulse ended before the divider");

	// a trigger on the last divider cycle restarts a full pulse
	a_retrigger_on_end: assert property (
		(r.vert && timer_done && set_evt) |=> (!VSYNC_N_O && (pulse_len == 20'h00000)))
		else $error("late trigger did not restart the vertical pulse");

	// a serration with the integrator short of the trigger level is ignored
	a_short_broad_quiet: assert property (
		(sync_end && (r.integ < lv.trigger) && !default_evt && !r.vert) |=> VSYNC_N_O)
		else $error("vertical pulse from a short broad pulse");

	// a long quiet gap before a sync pulse clears the field toggle
	a_toggle_gap_clear: assert property (
		(sync_start && (r.gap >= vss_pkg::FIELD_GAP_CYC)) |=> !r.toggle)
		else $error("field toggle not cleared after a long gap");

	// a short gap flips the field toggle
	a_toggle_short_flip: assert property (
		(sync_start && (r.gap < vss_pkg::FIELD_GAP_CYC)) |=> (r.toggle != $past(r.toggle)))
		else $error("field toggle did not flip on a short gap");

endmodule : vss_top

`default_nettype wire
